// File: pkg/rpf_pkg.sv
// constants for the recovery and programmed frequency select block
package rpf_pkg;
   localparam logic [7:0] RPF_ADDR_RECOV_N  = 8'h0B;
   localparam logic [7:0] RPF_ADDR_RECOV_SM = 8'h0C;
   localparam logic [7:0] RPF_ADDR_PROG_N   = 8'h0D;
   localparam logic [7:0] RPF_ADDR_PROG_EM  = 8'h0E;
   localparam logic [7:0] RPF_RESET_BYTE    = 8'h00;
   localparam int         RPF_SEL_BIT       = 7;
   localparam int         RPF_EN_BIT        = 7;
   localparam int         RPF_M_MSB         = 6;
   localparam int         RPF_N_WIDTH       = 8;
   localparam int         RPF_M_WIDTH       = 7;
   localparam int         RPF_CODE_WIDTH    = 5;

   typedef enum logic [1:0] {
      RPF_SRC_CODE       = 2'b00,
      RPF_SRC_PROGRAMMED = 2'b01,
      RPF_SRC_RECOV_CODE = 2'b10,
      RPF_SRC_RECOV_NM   = 2'b11
   } rpf_source_type;
endpackage

// File: rtl/rpf_byte_reg.sv
// one writable configuration byte with a write-accepted strobe
module rpf_byte_reg #(
   parameter logic [7:0] RESET_VALUE = 8'h00
) (
   input  wire logic       clock_in,
   input  wire logic       rst_n_in,
   input  wire logic       write_in,
   input  wire logic [7:0] data_in,
   output logic      [7:0] value_out,
   output logic            written_out
);
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         value_out <= RESET_VALUE;
      end else if (write_in) begin
         value_out <= data_in;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         written_out <= 1'b0;
      end else begin
         written_out <= write_in;
      end
   end
endmodule

// File: rtl/rpf_freq_select.sv
// cpu frequency source selection: strap, programmed and recovery
// Summary of operation
// - recovery source bit: 0 uses latched strap code, 1 uses recovery n/m
// - watchdog time-out switches cpu output to the selected recovery source
// - recovery n is 8 bits, recovery m is 7 bits
// - ratio code comes from strap when override clear, software code when set
// - programmable enable bit gates programmed frequency, resets to zero
// - when enabled, cpu frequency follows programmed n (8) and m (7)
// - writing the programmed m byte starts a load; host writes n first
// - time-out issues system reset, reloads recovery, locks recovery mode
// - in recovery mode, writes that change frequency are ignored
// - clearing watchdog enable leaves recovery mode
module rpf_freq_select (
   input  wire logic        clock_in,
   input  wire logic        rst_n_in,
   input  wire logic        write_in,
   input  wire logic [7:0]  write_addr_in,
   input  wire logic [7:0]  write_data_in,
   input  wire logic [7:0]  read_addr_in,
   output logic      [7:0]  read_data_out,
   input  wire logic [4:0]  strap_frequency_code_in,
   input  wire logic [4:0]  software_code_in,
   input  wire logic        ratio_override_in,
   input  wire logic        watchdog_enable_in,
   input  wire logic        watchdog_timeout_in,
   output logic      [1:0]  source_out,
   output logic      [7:0]  cpu_n_out,
   output logic      [6:0]  cpu_m_out,
   output logic      [4:0]  cpu_code_out,
   output logic      [4:0]  ratio_code_out,
   output logic             load_out,
   output logic             recovery_mode_out,
   output logic             system_reset_out
);
   logic [7:0]                 recov_n;
   logic [7:0]                 recov_sm;
   logic [7:0]                 prog_n;
   logic [7:0]                 prog_em;
   logic                       prog_m_written;
   logic                       wr_recov_n;
   logic                       wr_recov_sm;
   logic                       wr_prog_n;
   logic                       wr_prog_em;
   logic                       lock_q;
   logic                       timeout_hit;
   logic [4:0]                 strap_q;
   logic                       strap_taken_q;
   logic [4:0]                 sel_code;
   rpf_pkg::rpf_source_type    src_d;
   logic                       load_d;
   logic [7:0]                 n_d;
   logic [6:0]                 m_d;

   // frequency bytes are frozen while locked in recovery
   assign wr_recov_n  = write_in && !lock_q &&
                        write_addr_in == rpf_pkg::RPF_ADDR_RECOV_N;
   assign wr_recov_sm = write_in && !lock_q &&
                        write_addr_in == rpf_pkg::RPF_ADDR_RECOV_SM;
   assign wr_prog_n   = write_in && !lock_q &&
                        write_addr_in == rpf_pkg::RPF_ADDR_PROG_N;
   assign wr_prog_em  = write_in && !lock_q &&
                        write_addr_in == rpf_pkg::RPF_ADDR_PROG_EM;

   rpf_byte_reg #(.RESET_VALUE(rpf_pkg::RPF_RESET_BYTE)) u_recov_n (
      .clock_in    (clock_in),
      .rst_n_in    (rst_n_in),
      .write_in    (wr_recov_n),
      .data_in     (write_data_in),
      .value_out   (recov_n),
      .written_out ()
   );
   rpf_byte_reg #(.RESET_VALUE(rpf_pkg::RPF_RESET_BYTE)) u_recov_sm (
      .clock_in    (clock_in),
      .rst_n_in    (rst_n_in),
      .write_in    (wr_recov_sm),
      .data_in     (write_data_in),
      .value_out   (recov_sm),
      .written_out ()
   );
   rpf_byte_reg #(.RESET_VALUE(rpf_pkg::RPF_RESET_BYTE)) u_prog_n (
      .clock_in    (clock_in),
      .rst_n_in    (rst_n_in),
      .write_in    (wr_prog_n),
      .data_in     (write_data_in),
      .value_out   (prog_n),
      .written_out ()
   );
   // enable bit resets to zero with the m field
   rpf_byte_reg #(.RESET_VALUE(rpf_pkg::RPF_RESET_BYTE)) u_prog_em (
      .clock_in    (clock_in),
      .rst_n_in    (rst_n_in),
      .write_in    (wr_prog_em),
      .data_in     (write_data_in),
      .value_out   (prog_em),
      .written_out (prog_m_written)
   );

   // strap is a level caught after reset release, never under reset
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         strap_taken_q <= 1'b0;
      end else begin
         strap_taken_q <= 1'b1;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         strap_q <= 5'h00;
      end else if (!strap_taken_q) begin
         strap_q <= strap_frequency_code_in;
      end
   end

   // time-out only counts while the watchdog is armed
   assign timeout_hit = watchdog_timeout_in && watchdog_enable_in;

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lock_q <= 1'b0;
      end else if (!watchdog_enable_in) begin
         lock_q <= 1'b0;
      end else if (timeout_hit) begin
         lock_q <= 1'b1;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         system_reset_out <= 1'b0;
      end else begin
         system_reset_out <= timeout_hit && !lock_q;
      end
   end

   assign sel_code = ratio_override_in ? software_code_in : strap_q;

   always_comb begin
      src_d  = rpf_pkg::RPF_SRC_CODE;
      n_d    = 8'h00;
      m_d    = 7'h00;
      load_d = 1'b0;
      if (lock_q || timeout_hit) begin
         // recovery reloads on entry and holds until unlocked
         load_d = timeout_hit && !lock_q;
         if (recov_sm[rpf_pkg::RPF_SEL_BIT]) begin
            src_d = rpf_pkg::RPF_SRC_RECOV_NM;
            n_d   = recov_n;
            m_d   = recov_sm[rpf_pkg::RPF_M_MSB:0];
         end else begin
            src_d = rpf_pkg::RPF_SRC_RECOV_CODE;
         end
      end else if (prog_em[rpf_pkg::RPF_EN_BIT]) begin
         src_d  = rpf_pkg::RPF_SRC_PROGRAMMED;
         n_d    = prog_n;
         m_d    = prog_em[rpf_pkg::RPF_M_MSB:0];
         load_d = prog_m_written;
      end else begin
         src_d  = rpf_pkg::RPF_SRC_CODE;
         load_d = prog_m_written;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         source_out <= rpf_pkg::RPF_SRC_CODE;
         cpu_n_out  <= 8'h00;
         cpu_m_out  <= 7'h00;
      end else begin
         source_out <= src_d;
         cpu_n_out  <= n_d;
         cpu_m_out  <= m_d;
      end
   end

   // recovery from code always uses the latched strap, not software code
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cpu_code_out <= 5'h00;
      end else begin
         cpu_code_out <= (src_d == rpf_pkg::RPF_SRC_RECOV_CODE) ?
                         strap_q : sel_code;
      end
   end

   // ratio keeps following the override even while locked
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ratio_code_out <= 5'h00;
      end else begin
         ratio_code_out <= sel_code;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         load_out <= 1'b0;
      end else begin
         load_out <= load_d;
      end
   end

   // set on the time-out edge together with lock_q, cleared one cycle after it
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         recovery_mode_out <= 1'b0;
      end else begin
         recovery_mode_out <= lock_q || timeout_hit;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         read_data_out <= 8'h00;
      end else begin
         unique case (read_addr_in)
            rpf_pkg::RPF_ADDR_RECOV_N:  read_data_out <= recov_n;
            rpf_pkg::RPF_ADDR_RECOV_SM: read_data_out <= recov_sm;
            rpf_pkg::RPF_ADDR_PROG_N:   read_data_out <= prog_n;
            rpf_pkg::RPF_ADDR_PROG_EM:  read_data_out <= prog_em;
            default:                    read_data_out <= 8'h00;
         endcase
      end
   end
endmodule

// File: dv/rpf_host.sv
// host model that writes configuration bytes
module rpf_host (
   input  wire logic       clock_in,
   output logic            write_out = 1'b0,
   output logic      [7:0] addr_out  = 8'h00,
   output logic      [7:0] data_out  = 8'h00
);
   timeunit 1ns;
   timeprecision 1ns;
   // call at a falling edge; n byte must go before the m byte
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      write_out = 1'b1;
      addr_out  = a;
      data_out  = d;
      @(negedge clock_in);
      write_out = 1'b0;
      // released lines flip so stale data never looks valid
      addr_out  = ~a;
      data_out  = ~d;
      // idle edge keeps back-to-back strobes apart
      @(negedge clock_in);
   endtask
endmodule

// File: dv/rpf_chk.sv
// port checks for the frequency select block
module rpf_chk (
   input wire logic       clock_in,
   input wire logic       rst_n_in,
   input wire logic       write_in,
   input wire logic [7:0] write_addr_in,
   input wire logic [4:0] software_code_in,
   input wire logic       ratio_override_in,
   input wire logic       watchdog_enable_in,
   input wire logic       watchdog_timeout_in,
   input wire logic [1:0] source_out,
   input wire logic [4:0] ratio_code_out,
   input wire logic       load_out,
   input wire logic       recovery_mode_out,
   input wire logic       system_reset_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);
   // $past still sees reset values over the first edges
   logic [1:0] up_q;
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) up_q <= 2'h0;
      else if (up_q != 2'h3) up_q <= up_q + 2'h1;
   end
   a_timeout_enter: assert property (
      watchdog_timeout_in && watchdog_enable_in && !recovery_mode_out
      |=> system_reset_out && load_out && recovery_mode_out)
      else $error("timeout did not enter recovery");
   a_lock_hold: assert property (
      recovery_mode_out && watchdog_enable_in && $past(watchdog_enable_in)
      |=> recovery_mode_out) else $error("recovery lock dropped");
   a_unlock_exit: assert property (
      $fell(watchdog_enable_in) && recovery_mode_out
      |-> ##2 !recovery_mode_out) else $error("recovery lock not cleared");
   a_relock_quiet: assert property (
      recovery_mode_out && $past(recovery_mode_out) |-> !system_reset_out)
      else $error("reset while locked");
   a_source_recov: assert property (
      source_out[1] == recovery_mode_out) else $error("source and lock differ");
   a_ratio_soft: assert property (
      up_q == 2'h3 && $past(ratio_override_in)
      |-> ratio_code_out == $past(software_code_in)) else $error("bad ratio");
   a_load_on_m: assert property (
      write_in && write_addr_in == rpf_pkg::RPF_ADDR_PROG_EM &&
      !recovery_mode_out |-> ##2 load_out) else $error("m write did not load");
   a_reset_pulse: assert property (
      system_reset_out && watchdog_enable_in
      |=> !system_reset_out && recovery_mode_out) else $error("bad reset pulse");
   c_recov_nm: cover property (source_out == rpf_pkg::RPF_SRC_RECOV_NM);
   c_prog: cover property (source_out == rpf_pkg::RPF_SRC_PROGRAMMED);
   c_unlock: cover property ($fell(recovery_mode_out));
endmodule
bind rpf_freq_select rpf_chk u_chk (.clock_in(clock_in), .rst_n_in(rst_n_in),
   .write_in(write_in), .write_addr_in(write_addr_in),
   .software_code_in(software_code_in), .ratio_override_in(ratio_override_in),
   .watchdog_enable_in(watchdog_enable_in), .source_out(source_out),
   .watchdog_timeout_in(watchdog_timeout_in), .load_out(load_out),
   .ratio_code_out(ratio_code_out), .recovery_mode_out(recovery_mode_out),
   .system_reset_out(system_reset_out));

// File: dv/tb_top.sv
// self-checking bench for the frequency select block
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [7:0]  n, em;
      logic        ovr;
      logic [29:0] st;
   } rpf_row_type;
   localparam logic [4:0] STRAP = 5'h13;
   localparam logic [4:0] SOFT  = 5'h0A;
   logic       clock_in, rst_n_in, write_in, ovr, watchdog_enable, wd_to, load_o, rec_o;
   logic       sysrst_o;
   logic [7:0] waddr, wdata, raddr, rdata, n_o;
   logic [6:0] m_o;
   logic [4:0] code_o, ratio_o, strap;
   logic [1:0] src_o;
   int         err_total = 0;
   int         cmp_count = 0;
   // status word: load, lock, reset, source, n, m, code, ratio
   wire [29:0] st = {load_o, rec_o, sysrst_o, src_o, n_o, m_o, code_o, ratio_o};
   rpf_row_type rows [3] = '{
      '{8'h3C, 8'h85, 1'b0, {5'h11, 8'h3C, 7'h05, STRAP, STRAP}},
      '{8'h50, 8'h05, 1'b1, {5'h10, 8'h00, 7'h00, SOFT, SOFT}},
      '{8'hFF, 8'hFF, 1'b1, {5'h11, 8'hFF, 7'h7F, SOFT, SOFT}}};
   rpf_host u_host (.clock_in(clock_in), .write_out(write_in),
      .addr_out(waddr), .data_out(wdata));
   rpf_freq_select u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .write_in(write_in), .write_addr_in(waddr), .write_data_in(wdata),
      .read_addr_in(raddr), .read_data_out(rdata), .ratio_override_in(ovr),
      .strap_frequency_code_in(strap), .software_code_in(SOFT),
      .watchdog_enable_in(watchdog_enable), .watchdog_timeout_in(wd_to),
      .source_out(src_o), .cpu_n_out(n_o), .cpu_m_out(m_o),
      .cpu_code_out(code_o), .ratio_code_out(ratio_o), .load_out(load_o),
      .recovery_mode_out(rec_o), .system_reset_out(sysrst_o));
   task automatic chk(input string what, input logic [29:0] exp);
      cmp_count++;
      if (st !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, st);
      end
   endtask
   // two edges: one to store a fresh write, one for the read register
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      raddr = a;
      repeat (2) @(negedge clock_in);
      cmp_count++;
      if (rdata !== exp) begin
         err_total++;
         $display("unexpected byte %h: expected %h seen %h", a, exp, rdata);
      end
   endtask
   // returns while the one-cycle reset and load pulses still stand
   task automatic tmo();
      wd_to = 1'b1;
      @(negedge clock_in);
      wd_to = 1'b0;
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      clock_in = 1'b0;
      forever #25 clock_in = ~clock_in;
   end
   // run needs under 150 cycles; 400 leaves margin
   initial begin
      #20000;
      err_total++;
      complete_run();
   end
   initial begin
      rst_n_in = 1'b0;
      strap = STRAP;
      ovr = 1'b0;
      watchdog_enable = 1'b0;
      wd_to = 1'b0;
      raddr = 8'h00;
      repeat (10) @(negedge clock_in);
      rst_n_in = 1'b1;
      repeat (2) @(negedge clock_in);
      chk("reset", {5'h00, 15'h0, STRAP, STRAP});
      // a late pin change must not reach the latched strap
      strap = ~STRAP;
      for (int a = 11; a < 16; a++) rd(8'(a), 8'h00);
      $display("reset test done");
      foreach (rows[i]) begin
         ovr = rows[i].ovr;
         u_host.wr(rpf_pkg::RPF_ADDR_PROG_N, rows[i].n);
         u_host.wr(rpf_pkg::RPF_ADDR_PROG_EM, rows[i].em);
         // load pulse stands for one cycle right after the m write
         chk("row", rows[i].st);
         rd(rpf_pkg::RPF_ADDR_PROG_EM, rows[i].em);
         $display("row %0d done", i);
      end
      watchdog_enable = 1'b1;
      tmo();
      chk("strap recovery", {5'h1E, 15'h0, STRAP, SOFT});
      u_host.wr(rpf_pkg::RPF_ADDR_PROG_N, 8'h11);
      rd(rpf_pkg::RPF_ADDR_PROG_N, 8'hFF);
      tmo();
      chk("second timeout", {5'h0A, 15'h0, STRAP, SOFT});
      watchdog_enable = 1'b0;
      repeat (3) @(negedge clock_in);
      tmo();
      chk("unlock", {5'h01, 8'hFF, 7'h7F, SOFT, SOFT});
      $display("strap recovery test done");
      u_host.wr(rpf_pkg::RPF_ADDR_RECOV_N, 8'h77);
      u_host.wr(rpf_pkg::RPF_ADDR_RECOV_SM, 8'h85);
      watchdog_enable = 1'b1;
      @(negedge clock_in);
      tmo();
      chk("nm recovery", {5'h1F, 8'h77, 7'h05, SOFT, SOFT});
      $display("nm recovery test done");
      complete_run();
   end
endmodule
